//--- dv/bpm_pin_model.sv
// Pin-side model: each pin level is the block's drive where enabled, else the outside world.
// Assumes the bench sets the outside-world levels; no pull on any pin.
`timescale 1ns/1ps

module bpm_pin_model (
   input  logic [7:0] low_pin_out,
   input  logic [7:0] low_pin_oe_n,
   input  logic [7:0] high_pin_out,
   input  logic [7:0] high_pin_oe_n,
   input  logic [7:0] chg_pin_out,
   input  logic [7:0] chg_pin_oe_n,
   input  logic [7:0] ext_low,
   input  logic [7:0] ext_high,
   input  logic [7:0] ext_chg,
   output logic [7:0] low_pin_in,
   output logic [7:0] high_pin_in,
   output logic [7:0] chg_pin_in
);
   // Per-bit wired resolution; enable low means the block owns the bit
   assign low_pin_in  = (low_pin_out & ~low_pin_oe_n) | (ext_low & low_pin_oe_n);
   assign high_pin_in = (high_pin_out & ~high_pin_oe_n) | (ext_high & high_pin_oe_n);
   assign chg_pin_in  = (chg_pin_out & ~chg_pin_oe_n) | (ext_chg & chg_pin_oe_n);
endmodule // bpm_pin_model

//--- dv/bpm_top_asserts.sv
// Checker for the bus-muxed port block, bound to its top module.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/1ps

module bpm_top_asserts (
   input logic        aclk,
   input logic        aresetn,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic [7:0]  low_pin_in,
   input logic [7:0]  low_pin_out,
   input logic [7:0]  low_pin_oe_n,
   input logic [7:0]  high_pin_in,
   input logic [7:0]  high_pin_out,
   input logic [7:0]  high_pin_oe_n,
   input logic [7:0]  chg_pin_oe_n,
   input logic [15:0] bus_ad_drive,
   input logic [15:0] bus_ad_oe_n,
   input logic [15:0] bus_ad_sampled,
   input logic        bus_mode
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Cycles since reset release; saturates, so never wraps
   logic [3:0] up_cnt_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) up_cnt_ff <= 4'h0;
      else if (up_cnt_ff != 4'hf) up_cnt_ff <= up_cnt_ff + 4'h1;
   end

   chk_reset_idle: assert property (up_cnt_ff == 4'h1 |-> low_pin_oe_n == 8'hff && high_pin_oe_n == 8'hff
      && chg_pin_oe_n == 8'hff && !bus_mode) else $error("pins not released after reset");
   chk_bus_low: assert property (bus_mode && $past(bus_mode) |-> low_pin_out == $past(bus_ad_drive[7:0])
      && low_pin_oe_n == $past(bus_ad_oe_n[7:0])) else $error("low pins do not follow bus bits 7:0");
   chk_bus_high: assert property (bus_mode && $past(bus_mode) |-> high_pin_out == $past(bus_ad_drive[15:8])
      && high_pin_oe_n == $past(bus_ad_oe_n[15:8])) else $error("high pins do not follow bus bits 15:8");
   chk_bus_sample: assert property (up_cnt_ff > 4'h5 |-> bus_ad_sampled == $past({high_pin_in, low_pin_in}, 3))
      else $error("sampled bus value lags wrongly");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response not two cycles after handshake");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   chk_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");
   chk_mode_steady: assert property (up_cnt_ff > 4'h5 |-> $stable(bus_mode))
      else $error("bus mode changed after capture");
endmodule // bpm_top_asserts

bind bpm_top bpm_top_asserts chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .low_pin_in(low_pin_in), .low_pin_out(low_pin_out),
   .low_pin_oe_n(low_pin_oe_n), .high_pin_in(high_pin_in), .high_pin_out(high_pin_out),
   .high_pin_oe_n(high_pin_oe_n), .chg_pin_oe_n(chg_pin_oe_n), .bus_ad_drive(bus_ad_drive),
   .bus_ad_oe_n(bus_ad_oe_n), .bus_ad_sampled(bus_ad_sampled), .bus_mode(bus_mode));

//--- dv/bpm_top_tb_top.sv
// Self-checking bench for the bus-muxed port block over AXI4-Lite.
// Assumes the pin model resolves pins; write strobe lane 0 is always on.
`timescale 1ns/1ps
`include "bpm_consts.vh"

module bpm_top_tb_top;
   logic        aclk = 1'b0, aresetn = 1'b0, por_resetn = 1'b0;
   logic [1:0]  cfg_mode = 2'b10;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [15:0] bus_drv = 16'h0, bus_oe_n = 16'hffff;
   logic [7:0]  ext_low = 8'h3c, ext_high = 8'hc3, ext_chg = 8'h66;
   wire  [7:0]  lo_in, lo_out, lo_oe, hi_in, hi_out, hi_oe, cg_in, cg_out, cg_oe;
   wire         awready, wready, bvalid, arready, rvalid, bmode;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [15:0] smp;
   logic [7:0]  oe_a[3], out_a[3], ext_a[3];
   logic [7:0]  bk[3] = '{8'h01, 8'h01, 8'h00};
   logic [7:0]  di[3] = '{`BPM_IDX_LOW_DIR, `BPM_IDX_HIGH_DIR, `BPM_IDX_CHG_DIR};
   logic [7:0]  da[3] = '{`BPM_IDX_LOW_DATA, `BPM_IDX_HIGH_DATA, `BPM_IDX_CHG_DATA};
   integer      fail_count = 0, compares = 0;

   always #50 aclk = ~aclk;
   // Port views indexed like the register table above
   always_comb begin
      oe_a = '{lo_oe, hi_oe, cg_oe};
      out_a = '{lo_out, hi_out, cg_out};
      ext_a = '{ext_low, ext_high, ext_chg};
   end

   bpm_top dut_u (.aclk(aclk), .aresetn(aresetn), .por_resetn(por_resetn), .cfg_mode(cfg_mode),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .low_pin_in(lo_in), .low_pin_out(lo_out), .low_pin_oe_n(lo_oe),
      .high_pin_in(hi_in), .high_pin_out(hi_out), .high_pin_oe_n(hi_oe), .chg_pin_in(cg_in),
      .chg_pin_out(cg_out), .chg_pin_oe_n(cg_oe), .bus_ad_drive(bus_drv), .bus_ad_oe_n(bus_oe_n),
      .bus_ad_sampled(smp), .bus_mode(bmode));
   bpm_pin_model pins_u (.low_pin_out(lo_out), .low_pin_oe_n(lo_oe), .high_pin_out(hi_out),
      .high_pin_oe_n(hi_oe), .chg_pin_out(cg_out), .chg_pin_oe_n(cg_oe), .ext_low(ext_low),
      .ext_high(ext_high), .ext_chg(ext_chg), .low_pin_in(lo_in), .high_pin_in(hi_in), .chg_pin_in(cg_in));

   task report_and_stop;
      $display("Counts: compares=%0d mismatches=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Bounded handshake wait; a hung slave ends the run as a mismatch
   task automatic give_up(input logic hung);
      if (hung) begin
         check(32'h0, 32'h1, "handshake timeout");
         report_and_stop();
      end
   endtask

   // AXI write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
      integer n;
      @(posedge aclk);
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !bvalid; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      give_up(!bvalid);
      bready <= 1'b0;
      check(bresp, exp, "write response");
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp_d, input logic [1:0] exp);
      integer n;
      @(posedge aclk);
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && !rvalid; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      give_up(!rvalid);
      rready <= 1'b0;
      check(rresp, exp, "read response");
      check(rdata, {24'h0, exp_d}, "read data");
   endtask

   // Strap is caught once after reset
   task automatic rst(input logic [1:0] m, input logic por);
      cfg_mode <= m;
      aresetn <= 1'b0;
      por_resetn <= ~por;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      por_resetn <= 1'b1;
      repeat (6) @(posedge aclk);
   endtask

   initial begin
      rst(2'b10, 1'b1);
      rd(`BPM_IDX_CHG_DIR, 8'hff, `BPM_RESP_OKAY);
      wr(`BPM_IDX_BANK, 8'h01, `BPM_RESP_OKAY);
      rd(`BPM_IDX_LOW_DIR, 8'hff, `BPM_RESP_OKAY);
      rd(`BPM_IDX_HIGH_DIR, 8'hff, `BPM_RESP_OKAY);
      rd(`BPM_IDX_LOW_DATA, 8'h3c, `BPM_RESP_OKAY);
      check(lo_oe, 8'hff, "low released");
      $display("test reset_values done");
      // Mixed directions: pins read back outside level or own latch
      for (int p = 0; p < 3; p++) begin
         wr(`BPM_IDX_BANK, bk[p], `BPM_RESP_OKAY);
         wr(da[p], 8'h00, `BPM_RESP_OKAY);
         wr(da[p], 8'ha5, `BPM_RESP_OKAY);
         wr(di[p], 8'hf0, `BPM_RESP_OKAY);
         repeat (4) @(posedge aclk);
         check(oe_a[p], 8'hf0, "port enables");
         check(out_a[p] & 8'h0f, 8'h05, "port drive");
         rd(da[p], (ext_a[p] & 8'hf0) | 8'h05, `BPM_RESP_OKAY);
      end
      $display("test gpio_ports done");
      rd(`BPM_IDX_LOW_DIR, 8'h00, `BPM_RESP_SLVERR);
      wr(`BPM_IDX_LOW_DIR, 8'h00, `BPM_RESP_SLVERR);
      rd(8'h3f, 8'h00, `BPM_RESP_SLVERR);
      check(lo_oe, 8'hf0, "refused write kept");
      $display("test refusals done");
      // Warm reset keeps the latch; enabling outputs shows it
      rst(2'b11, 1'b0);
      check(lo_oe, 8'hff, "warm reset released");
      wr(`BPM_IDX_BANK, 8'h01, `BPM_RESP_OKAY);
      wr(`BPM_IDX_LOW_DIR, 8'h00, `BPM_RESP_OKAY);
      repeat (4) @(posedge aclk);
      check(lo_out, 8'ha5, "latch kept");
      $display("test warm_reset done");
      for (int m = 0; m < 4; m++) begin
         rst(m[1:0], 1'b1);
         check(bmode, m < 2, "bus mode");
         rd(`BPM_IDX_STATUS, {5'h00, m[1:0], m < 2}, `BPM_RESP_OKAY);
         if (m == 1) begin
            bus_drv <= 16'h1234;
            bus_oe_n <= 16'h0ff0;
            ext_low <= 8'h5a;
            wr(`BPM_IDX_BANK, 8'h01, `BPM_RESP_OKAY);
            wr(`BPM_IDX_LOW_DIR, 8'h00, `BPM_RESP_OKAY);
            repeat (6) @(posedge aclk);
            check(lo_oe, 8'hf0, "bus low enables");
            check(lo_out & 8'h0f, 8'h04, "bus low drive");
            check(hi_oe, 8'h0f, "bus high enables");
            check(hi_out & 8'hf0, 8'h10, "bus high drive");
            check(smp, 16'h1354, "bus sampled");
            bus_oe_n <= 16'hffff;
         end
      end
      $display("test bus_modes done");
      report_and_stop();
   end
endmodule // bpm_top_tb_top

//--- verilog/bpm_consts.vh
// Constants for the bus-muxed bidirectional port block: register indices,
// bank codes, selector codes, reset values and configuration mode codes.
// Assumes it is included by bare name from the design files.
`ifndef BPM_CONSTS_VH
`define BPM_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BPM_IDX_BANK        8'h00
`define BPM_IDX_STATUS      8'h01
`define BPM_IDX_LOW_DIR     8'h10
`define BPM_IDX_CHG_DIR     8'h11
`define BPM_IDX_LOW_DATA    8'h11
`define BPM_IDX_CHG_DATA    8'h12
`define BPM_IDX_HIGH_DIR    8'h12
`define BPM_IDX_HIGH_DATA   8'h13

// ----------------------------------------------------------------
// Bank selector
// ----------------------------------------------------------------
`define BPM_BANK_W          4
`define BPM_BANK0           4'h0
`define BPM_BANK1           4'h1
`define BPM_BANK_RESET      4'h0

// ----------------------------------------------------------------
// Internal register selector codes
// ----------------------------------------------------------------
`define BPM_SEL_NONE        4'h0
`define BPM_SEL_BANK        4'h1
`define BPM_SEL_STAT        4'h2
`define BPM_SEL_LDIR        4'h3
`define BPM_SEL_LDAT        4'h4
`define BPM_SEL_CDIR        4'h5
`define BPM_SEL_CDAT        4'h6
`define BPM_SEL_HDIR        4'h7
`define BPM_SEL_HDAT        4'h8

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define BPM_DIR_RESET       8'hff
`define BPM_LATCH_POR       8'h00
`define BPM_STAT_BUS_BIT    0
`define BPM_STAT_MODE_LSB   1
`define BPM_STAT_MODE_MSB   2

// ----------------------------------------------------------------
// Configuration modes
// ----------------------------------------------------------------
`define BPM_MODE_MPU        2'b00
`define BPM_MODE_EXT_MCU    2'b01
`define BPM_MODE_MCU        2'b10
`define BPM_MODE_MCU_PROT   2'b11

// ----------------------------------------------------------------
// AXI responses and address split
// ----------------------------------------------------------------
`define BPM_ADDR_W          12
`define BPM_RESP_OKAY       2'b00
`define BPM_RESP_SLVERR     2'b10

`endif

//--- verilog/bpm_sync.v
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no multi-bit coherence given.
`timescale 1ns/1ps

module bpm_sync #(
   parameter W = 8
) (
   aclk,
   aresetn,
   async_in,
   sync_out
);
   input  wire         aclk;
   input  wire         aresetn;
   input  wire [W-1:0] async_in;
   output wire [W-1:0] sync_out;

   reg [W-1:0] meta_ff;
   reg [W-1:0] stable_ff;

   // ----------------------------------------------------------------
   // Synchroniser chain
   // ----------------------------------------------------------------
   // First stage feeds only the second stage
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff   <= {W{1'b0}};
         stable_ff <= {W{1'b0}};
      end else begin
         meta_ff   <= async_in;
         stable_ff <= meta_ff;
      end
   end

   assign sync_out = stable_ff;

endmodule // bpm_sync

//--- verilog/bpm_top.v
// What this block does
// - Low-byte port: eight pins, latch, direction each
// - Low-byte direction one: pin input, driver off
// - Low-byte direction zero: pin drives latch
// - Low-byte data read pins, write latch
// - Bus mode: low pins carry bus bits 7:0
// - Processor/extended modes select bus, others GPIO
// - High-byte port: eight pins, latch, direction each
// - High-byte direction one: pin input
// - High-byte direction zero: pin drives latch
// - High-byte data read pins, write latch
// - Bus mode: high pins carry bus bits 15:8
// - Change-port direction resets to all ones
// - Latches undefined at power-on, kept otherwise
//
// Top of the bus-muxed port block: AXI4-Lite register slave, three
// 8-bit ports, pin muxing toward the external address/data bus.
// Assumes pins are asynchronous; bus drive signals come from logic on aclk.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "bpm_consts.vh"

module bpm_top (
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire                   por_resetn,
   input  wire [1:0]             cfg_mode,
   input  wire [`BPM_ADDR_W-1:0] s_axi_awaddr,
   input  wire                   s_axi_awvalid,
   output wire                   s_axi_awready,
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output wire                   s_axi_wready,
   output wire [1:0]             s_axi_bresp,
   output wire                   s_axi_bvalid,
   input  wire                   s_axi_bready,
   input  wire [`BPM_ADDR_W-1:0] s_axi_araddr,
   input  wire                   s_axi_arvalid,
   output wire                   s_axi_arready,
   output wire [31:0]            s_axi_rdata,
   output wire [1:0]             s_axi_rresp,
   output wire                   s_axi_rvalid,
   input  wire                   s_axi_rready,
   input  wire [7:0]             low_pin_in,
   output wire [7:0]             low_pin_out,
   output wire [7:0]             low_pin_oe_n,
   input  wire [7:0]             high_pin_in,
   output wire [7:0]             high_pin_out,
   output wire [7:0]             high_pin_oe_n,
   input  wire [7:0]             chg_pin_in,
   output wire [7:0]             chg_pin_out,
   output wire [7:0]             chg_pin_oe_n,
   input  wire [15:0]            bus_ad_drive,
   input  wire [15:0]            bus_ad_oe_n,
   output wire [15:0]            bus_ad_sampled,
   output wire                   bus_mode
);

   // ----------------------------------------------------------------
   // Decode and write-merge helpers
   // ----------------------------------------------------------------
   // Same decode serves reads and writes so both see one map
   function [3:0] reg_sel;
      input [7:0]             idx;
      input [`BPM_BANK_W-1:0] bank;
      begin
         reg_sel = `BPM_SEL_NONE;
         if (idx == `BPM_IDX_BANK)
            reg_sel = `BPM_SEL_BANK;
         else if (idx == `BPM_IDX_STATUS)
            reg_sel = `BPM_SEL_STAT;
         else if (bank == `BPM_BANK1) begin
            case (idx)
               `BPM_IDX_LOW_DIR:   reg_sel = `BPM_SEL_LDIR;
               `BPM_IDX_LOW_DATA:  reg_sel = `BPM_SEL_LDAT;
               `BPM_IDX_HIGH_DIR:  reg_sel = `BPM_SEL_HDIR;
               `BPM_IDX_HIGH_DATA: reg_sel = `BPM_SEL_HDAT;
               default:            reg_sel = `BPM_SEL_NONE;
            endcase
         end else if (bank == `BPM_BANK0) begin
            case (idx)
               `BPM_IDX_CHG_DIR:  reg_sel = `BPM_SEL_CDIR;
               `BPM_IDX_CHG_DATA: reg_sel = `BPM_SEL_CDAT;
               default:           reg_sel = `BPM_SEL_NONE;
            endcase
         end
      end
   endfunction

   // Only byte lane 0 carries register data
   function [7:0] merge_byte;
      input [7:0] old;
      input [7:0] data;
      input       lane_en;
      begin
         merge_byte = lane_en ? data : old;
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin and configuration synchronisers
   // ----------------------------------------------------------------
   wire [25:0] pins_sync;

   bpm_sync #(
      .W (26)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({cfg_mode, chg_pin_in, high_pin_in, low_pin_in}),
      .sync_out (pins_sync)
   );

   wire [7:0] low_lvl  = pins_sync[7:0];
   wire [7:0] high_lvl = pins_sync[15:8];
   wire [7:0] chg_lvl  = pins_sync[23:16];
   wire [1:0] cfg_lvl  = pins_sync[25:24];

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg [`BPM_BANK_W-1:0] bank_ff;
   reg [1:0]             mode_ff, sync_age_ff, bresp_ff, rresp_ff;
   reg                   mode_taken_ff, bus_mode_ff;
   reg [7:0]             low_dir_ff, high_dir_ff, chg_dir_ff;
   reg [7:0]             low_latch_ff, high_latch_ff, chg_latch_ff;
   reg [7:0]             low_out_ff, high_out_ff, chg_out_ff;
   reg [7:0]             low_oe_n_ff, high_oe_n_ff, chg_oe_n_ff;
   reg [7:0]             aw_idx_ff, w_data_ff;
   reg [15:0]            bus_samp_ff;
   reg [31:0]            rdata_ff;
   reg                   aw_hold_ff, w_hold_ff, w_lane_ff, bvalid_ff;
   reg                   awready_ff, wready_ff, arready_ff, rvalid_ff;

   // ----------------------------------------------------------------
   // Configuration mode capture
   // ----------------------------------------------------------------
   // Mode is a strap: caught once, after the synchroniser has settled
   // past reset release, so a late strap edge cannot flip the bus mid-run
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync_age_ff   <= 2'd0;
         mode_taken_ff <= 1'b0;
         mode_ff       <= `BPM_MODE_MCU;
         bus_mode_ff   <= 1'b0;
      end else begin
         if (sync_age_ff != 2'd2)
            sync_age_ff <= sync_age_ff + 2'd1;
         else if (!mode_taken_ff) begin
            mode_taken_ff <= 1'b1;
            mode_ff       <= cfg_lvl;
            bus_mode_ff   <= (cfg_lvl == `BPM_MODE_MPU) ||
                             (cfg_lvl == `BPM_MODE_EXT_MCU);
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI write channel
   // ----------------------------------------------------------------
   wire       aw_fire  = s_axi_awvalid && awready_ff;
   wire       w_fire   = s_axi_wvalid && wready_ff;
   wire       b_fire   = bvalid_ff && s_axi_bready;
   wire       wr_go    = aw_hold_ff && w_hold_ff && !bvalid_ff;
   wire [3:0] wr_sel   = reg_sel(aw_idx_ff, bank_ff);
   wire       nxt_aw_hold = wr_go ? 1'b0 : (aw_hold_ff || aw_fire);
   wire       nxt_w_hold  = wr_go ? 1'b0 : (w_hold_ff || w_fire);
   wire       nxt_bvalid  = wr_go ? 1'b1 : (bvalid_ff && !b_fire);

   // Address and data are taken in either order; the write lands once
   // both are held and the previous response has gone
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         aw_idx_ff  <= 8'h00;
         w_hold_ff  <= 1'b0;
         w_data_ff  <= 8'h00;
         w_lane_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `BPM_RESP_OKAY;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
      end else begin
         if (aw_fire)
            aw_idx_ff <= s_axi_awaddr[9:2];
         if (w_fire) begin
            w_data_ff <= s_axi_wdata[7:0];
            w_lane_ff <= s_axi_wstrb[0];
         end
         if (wr_go)
            bresp_ff <= (wr_sel == `BPM_SEL_NONE) ? `BPM_RESP_SLVERR : `BPM_RESP_OKAY;
         aw_hold_ff <= nxt_aw_hold;
         w_hold_ff  <= nxt_w_hold;
         bvalid_ff  <= nxt_bvalid;
         awready_ff <= !nxt_aw_hold && !nxt_bvalid;
         wready_ff  <= !nxt_w_hold && !nxt_bvalid;
      end
   end

   // ----------------------------------------------------------------
   // Bank selector and direction registers
   // ----------------------------------------------------------------
   // Only aresetn reloads directions (por_resetn does not), so all pins start as inputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         bank_ff     <= `BPM_BANK_RESET;
         low_dir_ff  <= `BPM_DIR_RESET;
         high_dir_ff <= `BPM_DIR_RESET;
         chg_dir_ff  <= `BPM_DIR_RESET;
      end else if (wr_go) begin
         case (wr_sel)
            `BPM_SEL_BANK: bank_ff     <= w_lane_ff ? w_data_ff[`BPM_BANK_W-1:0] : bank_ff;
            `BPM_SEL_LDIR: low_dir_ff  <= merge_byte(low_dir_ff, w_data_ff, w_lane_ff);
            `BPM_SEL_HDIR: high_dir_ff <= merge_byte(high_dir_ff, w_data_ff, w_lane_ff);
            `BPM_SEL_CDIR: chg_dir_ff  <= merge_byte(chg_dir_ff, w_data_ff, w_lane_ff);
            default:       bank_ff     <= bank_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output latches
   // ----------------------------------------------------------------
   // Latches ignore aresetn so pin and watchdog resets keep them; only
   // power-on clears them, zero standing in for an unknown value
   always @(posedge aclk) begin
      if (!por_resetn) begin
         low_latch_ff  <= `BPM_LATCH_POR;
         high_latch_ff <= `BPM_LATCH_POR;
         chg_latch_ff  <= `BPM_LATCH_POR;
      end else if (wr_go) begin
         case (wr_sel)
            `BPM_SEL_LDAT: low_latch_ff  <= merge_byte(low_latch_ff, w_data_ff, w_lane_ff);
            `BPM_SEL_HDAT: high_latch_ff <= merge_byte(high_latch_ff, w_data_ff, w_lane_ff);
            `BPM_SEL_CDAT: chg_latch_ff  <= merge_byte(chg_latch_ff, w_data_ff, w_lane_ff);
            default:       low_latch_ff  <= low_latch_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // AXI read channel
   // ----------------------------------------------------------------
   wire       ar_fire = s_axi_arvalid && arready_ff;
   wire       r_fire  = rvalid_ff && s_axi_rready;
   wire [3:0] rd_sel  = reg_sel(s_axi_araddr[9:2], bank_ff);
   wire       nxt_rvalid = ar_fire ? 1'b1 : (rvalid_ff && !r_fire);
   reg  [7:0] rd_byte;

   // Data registers return pin levels, not latch contents
   always @* begin
      rd_byte = 8'h00;
      case (rd_sel)
         `BPM_SEL_BANK: rd_byte = {4'h0, bank_ff};
         `BPM_SEL_STAT: rd_byte = {5'h00, mode_ff, bus_mode_ff};
         `BPM_SEL_LDIR: rd_byte = low_dir_ff;
         `BPM_SEL_LDAT: rd_byte = low_lvl;
         `BPM_SEL_HDIR: rd_byte = high_dir_ff;
         `BPM_SEL_HDAT: rd_byte = high_lvl;
         `BPM_SEL_CDIR: rd_byte = chg_dir_ff;
         `BPM_SEL_CDAT: rd_byte = chg_lvl;
         default:       rd_byte = 8'h00;
      endcase
   end

   // One read in flight; next address accepted after rdata is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `BPM_RESP_OKAY;
         arready_ff <= 1'b0;
      end else begin
         if (ar_fire) begin
            rdata_ff <= {24'h00_0000, rd_byte};
            rresp_ff <= (rd_sel == `BPM_SEL_NONE) ? `BPM_RESP_SLVERR : `BPM_RESP_OKAY;
         end
         rvalid_ff  <= nxt_rvalid;
         arready_ff <= !nxt_rvalid;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // In bus mode the low and high latch and direction bits are bypassed (the
   // change port stays on its own); they keep their values so a later GPIO phase resumes cleanly
   always @(posedge aclk) begin
      if (!aresetn) begin
         low_out_ff   <= 8'h00;
         low_oe_n_ff  <= 8'hff;
         high_out_ff  <= 8'h00;
         high_oe_n_ff <= 8'hff;
         chg_out_ff   <= 8'h00;
         chg_oe_n_ff  <= 8'hff;
         bus_samp_ff  <= 16'h0000;
      end else begin
         if (bus_mode_ff) begin
            low_out_ff   <= bus_ad_drive[7:0];
            low_oe_n_ff  <= bus_ad_oe_n[7:0];
            high_out_ff  <= bus_ad_drive[15:8];
            high_oe_n_ff <= bus_ad_oe_n[15:8];
         end else begin
            low_out_ff   <= low_latch_ff;
            low_oe_n_ff  <= low_dir_ff;
            high_out_ff  <= high_latch_ff;
            high_oe_n_ff <= high_dir_ff;
         end
         chg_out_ff  <= chg_latch_ff;
         chg_oe_n_ff <= chg_dir_ff;
         bus_samp_ff <= {high_lvl, low_lvl};
      end
   end

   // ----------------------------------------------------------------
   // Output assignments
   // ----------------------------------------------------------------
   assign s_axi_awready  = awready_ff;
   assign s_axi_wready   = wready_ff;
   assign s_axi_bresp    = bresp_ff;
   assign s_axi_bvalid   = bvalid_ff;
   assign s_axi_arready  = arready_ff;
   assign s_axi_rdata    = rdata_ff;
   assign s_axi_rresp    = rresp_ff;
   assign s_axi_rvalid   = rvalid_ff;
   assign low_pin_out    = low_out_ff;
   assign low_pin_oe_n   = low_oe_n_ff;
   assign high_pin_out   = high_out_ff;
   assign high_pin_oe_n  = high_oe_n_ff;
   assign chg_pin_out    = chg_out_ff;
   assign chg_pin_oe_n   = chg_oe_n_ff;
   assign bus_ad_sampled = bus_samp_ff;
   assign bus_mode       = bus_mode_ff;

endmodule // bpm_top
